/* des_regs.svh */
// constants: round counts, user controller register map, field positions, reset values
`ifndef DES_REGS_SVH
`define DES_REGS_SVH

`define DES_CNT_ZERO 4'h0
`define DES_CNT_LAST 4'hF

`define UC_CTRL_OFS 8'h00
`define UC_STAT_OFS 8'h04
`define UC_MASK_OFS 8'h08
`define UC_KEYH_OFS 8'h10
`define UC_KEYL_OFS 8'h14
`define UC_DINH_OFS 8'h18
`define UC_DINL_OFS 8'h1C
`define UC_DOUTH_OFS 8'h20
`define UC_DOUTL_OFS 8'h24

`define CTRL_START_BIT 0
`define CTRL_WAY_BIT 1
`define CTRL_PWATCH_BIT 2
`define CTRL_ABORT_BIT 3
`define CTRL_STREAM_BIT 4

`define STAT_DONE_BIT 0
`define STAT_PFAULT_BIT 1
`define STAT_FAULT_NOW_BIT 2
`define STAT_BUSY_BIT 3

`define UC_MASK_RST 2'h0
`define UC_WAY_RST 1'h1
`define UC_PWATCH_RST 1'h0
`define UC_STREAM_RST 1'h0

`endif

/* des_pkg.sv */
// shared types for the block cipher engine and its user controller
package des_pkg;
    typedef logic [1:64] block_t;
    typedef logic [1:56] cd_t;
    typedef logic [1:48] subkey_t;
    typedef logic [1:32] half_t;
    typedef logic [1:28] half_cd_t;
    typedef enum logic [2:0] {
        UC_IDLE = 3'h1,
        UC_RUN = 3'h2,
        UC_CLEAR = 3'h4
    } uc_state_t;
endpackage

/* des_link_if.sv */
// link between the user controller and the cipher engine
`timescale 1ns/100ps
interface des_link_if;
    logic async_low_rst_n;
    logic abort_pulse;
    logic run_gate;
    logic cipher_way;
    logic parity_watch;
    des_pkg::block_t key;
    des_pkg::block_t din;
    des_pkg::block_t dout;
    logic result_strobe;
    logic parity_fault;
    modport engine (
        input async_low_rst_n, abort_pulse, run_gate, cipher_way, parity_watch, key, din,
        output dout, result_strobe, parity_fault
    );
    modport user (
        output async_low_rst_n, abort_pulse, run_gate, cipher_way, parity_watch, key, din,
        input dout, result_strobe, parity_fault
    );
endinterface

/* des_round.sv */
// one cipher round function: expansion, key mix, substitution boxes, permutation
`timescale 1ns/100ps
module des_round (
    input wire des_pkg::half_t r_half_i, // right half entering the round
    input wire des_pkg::subkey_t subkey_i, // round subkey
    output des_pkg::half_t f_o // round function result
);
    // each box: four rows of sixteen nibbles, entry 0 in the top nibble
    localparam logic [0:7][255:0] SBOX = '{
        256'hE4D12FB83A6C5907_0F74E2D1A6CB9538_41E8D62BFC973A50_FC8249175B3EA06D,
        256'hF18E6B34972DC05A_3D47F28EC01A69B5_0E7BA4D158C6932F_D8A13F42B67C05E9,
        256'hA09E63F51DC7B428_D709346A285ECBF1_D6498F30B12C5AE7_1AD069874FE3B52C,
        256'h7DE3069A1285BC4F_D8B56F03472C1AE9_A690CB7DF13E5284_3F06A1D8945BC72E,
        256'h2C417AB6853FD0E9_EB2C47D150FA3986_421BAD78F9C5630E_B8C71E2D6F09A453,
        256'hC1AF92680D34E75B_AF427C9561DE0B38_9EF528C3704A1DB6_432C95FABE17608D,
        256'h4B2EF08D3C975A61_D0B7491AE35C2F86_14BDC37EAF680592_6BD814A7950FE23C,
        256'hD2846FB1A93E50C7_1FD8A374C56B0E92_7B419CE206ADF358_21E74A8DFC90356B
    };
    localparam int P_T [1:32] = '{16, 7, 20, 21, 29, 12, 28, 17, 1, 15, 23, 26, 5, 18, 31, 10,
                                  2, 8, 24, 14, 32, 27, 3, 9, 19, 13, 30, 6, 22, 11, 4, 25};

    // expansion wraps the half around so each group of six overlaps its neighbours
    function automatic des_pkg::subkey_t expand_f(input des_pkg::half_t x);
        des_pkg::subkey_t y;
        y = '0;
        for (int j = 0; j < 8; j++) begin
            for (int k = 0; k < 6; k++) begin
                y[6 * j + k + 1] = x[((4 * j + k + 31) % 32) + 1];
            end
        end
        return y;
    endfunction

    function automatic logic [3:0] sbox_f(input int n, input logic [5:0] b);
        logic [5:0] idx;
        idx = {b[5], b[0], b[4:1]};
        return SBOX[n][(8'(63) - 8'(idx)) * 4 +: 4];
    endfunction

    des_pkg::subkey_t mixed_w;
    des_pkg::half_t sub_w;

    assign mixed_w = expand_f(r_half_i) ^ subkey_i;

    always_comb begin
        sub_w = '0;
        for (int j = 0; j < 8; j++) begin
            sub_w[4 * j + 1 +: 4] = sbox_f(j, mixed_w[6 * j + 1 +: 6]);
        end
        f_o = '0;
        for (int i = 1; i <= 32; i++) begin
            f_o[i] = sub_w[P_T[i]];
        end
    end
endmodule

/* des_engine.sv */
// device end: iterative electronic codebook block cipher engine on the link
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "des_regs.svh"
module des_engine (
    input wire logic SYS_CLK_I, // system clock
    input wire logic RST_I, // synchronous reset, active high
    input wire logic CE_I, // clock enable, all state frozen while low
    des_link_if.engine lnk // key, data and control in, result out
);
    localparam int PC1_T [1:56] = '{
        57, 49, 41, 33, 25, 17, 9, 1, 58, 50, 42, 34, 26, 18,
        10, 2, 59, 51, 43, 35, 27, 19, 11, 3, 60, 52, 44, 36,
        63, 55, 47, 39, 31, 23, 15, 7, 62, 54, 46, 38, 30, 22,
        14, 6, 61, 53, 45, 37, 29, 21, 13, 5, 28, 20, 12, 4
    };
    localparam int PC2_T [1:48] = '{
        14, 17, 11, 24, 1, 5, 3, 28, 15, 6, 21, 10,
        23, 19, 12, 4, 26, 8, 16, 7, 27, 20, 13, 2,
        41, 52, 31, 37, 47, 55, 30, 40, 51, 45, 33, 48,
        44, 49, 39, 56, 34, 53, 46, 42, 50, 36, 29, 32
    };

    // source bit of the initial permutation for output position i (0 based)
    function automatic int ip_src_f(input int i);
        int r;
        int c;
        r = i / 8;
        c = i % 8;
        return (r < 4) ? (58 + 2 * r - 8 * c) : (57 + 2 * (r - 4) - 8 * c);
    endfunction

    function automatic des_pkg::block_t ip_f(input des_pkg::block_t x);
        des_pkg::block_t y;
        y = '0;
        for (int i = 0; i < 64; i++) begin
            y[i + 1] = x[ip_src_f(i)];
        end
        return y;
    endfunction

    // final permutation is the exact inverse of the initial one
    function automatic des_pkg::block_t fp_f(input des_pkg::block_t x);
        des_pkg::block_t y;
        y = '0;
        for (int i = 0; i < 64; i++) begin
            y[ip_src_f(i)] = x[i + 1];
        end
        return y;
    endfunction

    // the table never names positions 8, 16 .. 64, so parity bits stay out
    function automatic des_pkg::cd_t pc1_f(input des_pkg::block_t k);
        des_pkg::cd_t y;
        y = '0;
        for (int i = 1; i <= 56; i++) begin
            y[i] = k[PC1_T[i]];
        end
        return y;
    endfunction

    function automatic des_pkg::subkey_t pc2_f(input des_pkg::cd_t cd);
        des_pkg::subkey_t y;
        y = '0;
        for (int i = 1; i <= 48; i++) begin
            y[i] = cd[PC2_T[i]];
        end
        return y;
    endfunction

    // decryption walks the schedule backwards: no shift first, then right shifts
    function automatic logic [1:0] shift_amt_f(input logic [3:0] cnt, input logic way);
        logic single;
        single = (cnt == 4'h0) || (cnt == 4'h1) || (cnt == 4'h8) || (cnt == 4'hF);
        if (way) begin
            return single ? 2'h1 : 2'h2;
        end
        if (cnt == 4'h0) begin
            return 2'h0;
        end
        return (cnt == 4'h1 || cnt == 4'h8 || cnt == 4'hF) ? 2'h1 : 2'h2;
    endfunction

    function automatic des_pkg::half_cd_t rot_f(input des_pkg::half_cd_t x, input logic [1:0] n,
                                                input logic left);
        des_pkg::half_cd_t y;
        y = x;
        case (n)
            2'h1: y = left ? {x[2:28], x[1]} : {x[28], x[1:27]};
            2'h2: y = left ? {x[3:28], x[1:2]} : {x[27:28], x[1:26]};
            default: y = x;
        endcase
        return y;
    endfunction

    function automatic logic parity_bad_f(input des_pkg::block_t k);
        logic bad;
        bad = 1'b0;
        for (int b = 0; b < 8; b++) begin
            bad = bad | ~(^k[8 * b + 1 +: 8]);
        end
        return bad;
    endfunction

    logic [3:0] cnt_r;
    des_pkg::block_t lr_r;
    des_pkg::cd_t cd_r;
    des_pkg::block_t dout_r;
    logic strobe_r;
    logic pfault_r;

    logic first_w;
    logic last_w;
    logic [1:0] amt_w;
    logic pbad_w;
    des_pkg::block_t src_lr_w;
    des_pkg::cd_t src_cd_w;
    des_pkg::cd_t cd_nxt;
    des_pkg::subkey_t subkey_w;
    des_pkg::half_t f_w;
    des_pkg::block_t lr_nxt;
    des_pkg::block_t out_w;
    logic [3:0] cnt_nxt;

    assign first_w = (cnt_r == `DES_CNT_ZERO);
    assign last_w = (cnt_r == `DES_CNT_LAST);
    // every block starts from the din bus; nothing from the last block is fed back
    assign src_lr_w = first_w ? ip_f(lnk.din) : lr_r;
    assign src_cd_w = first_w ? pc1_f(lnk.key) : cd_r;
    assign amt_w = shift_amt_f(cnt_r, lnk.cipher_way);
    assign cd_nxt = {rot_f(src_cd_w[1:28], amt_w, lnk.cipher_way),
                     rot_f(src_cd_w[29:56], amt_w, lnk.cipher_way)};
    assign subkey_w = pc2_f(cd_nxt);
    assign lr_nxt = {src_lr_w[33:64], src_lr_w[1:32] ^ f_w};
    // halves swap before the final permutation, undoing the last round's swap
    assign out_w = fp_f({lr_nxt[33:64], lr_nxt[1:32]});
    assign cnt_nxt = cnt_r + 4'h1;
    assign pbad_w = parity_bad_f(lnk.key);

    des_round u_round (
        .r_half_i(src_lr_w[33:64]),
        .subkey_i(subkey_w),
        .f_o(f_w)
    );

    // control path: round counter, result register, strobe, parity flag
    always_ff @(posedge SYS_CLK_I or negedge lnk.async_low_rst_n) begin
        if (!lnk.async_low_rst_n) begin
            cnt_r <= `DES_CNT_ZERO;
            dout_r <= '0;
            strobe_r <= 1'b0;
            pfault_r <= 1'b0;
        end else if (RST_I) begin
            cnt_r <= `DES_CNT_ZERO;
            dout_r <= '0;
            strobe_r <= 1'b0;
            pfault_r <= 1'b0;
        end else if (CE_I) begin
            pfault_r <= lnk.parity_watch & pbad_w;
            if (lnk.abort_pulse) begin
                cnt_r <= `DES_CNT_ZERO;
                strobe_r <= 1'b0;
            end else begin
                strobe_r <= lnk.run_gate & last_w;
                if (lnk.run_gate) begin
                    cnt_r <= cnt_nxt;
                    if (last_w) begin
                        dout_r <= out_w;
                    end
                end
            end
        end
    end

    // data and key schedule: held while the gate is low, wiped by an abort
    always_ff @(posedge SYS_CLK_I or negedge lnk.async_low_rst_n) begin
        if (!lnk.async_low_rst_n) begin
            lr_r <= '0;
            cd_r <= '0;
        end else if (RST_I) begin
            lr_r <= '0;
            cd_r <= '0;
        end else if (CE_I) begin
            if (lnk.abort_pulse) begin
                lr_r <= '0;
                cd_r <= '0;
            end else if (lnk.run_gate) begin
                lr_r <= lr_nxt;
                cd_r <= cd_nxt;
            end
        end
    end

    assign lnk.dout = dout_r;
    assign lnk.result_strobe = strobe_r;
    assign lnk.parity_fault = pfault_r;
endmodule

/* des_user_ctrl.sv */
// user end: register-driven controller that feeds the engine and captures results
`timescale 1ns/100ps
`include "des_regs.svh"
module des_user_ctrl (
    input wire logic SYS_CLK_I, // system clock
    input wire logic RST_I, // synchronous reset, active high
    input wire logic CE_I, // clock enable, all state frozen while low
    input wire logic [7:0] ADDR_I, // register byte address
    input wire logic [31:0] WDATA_I, // write data
    input wire logic WR_I, // write strobe
    input wire logic RD_I, // read strobe
    output logic [31:0] RDATA_O, // read data, cycle after the read strobe
    output logic IRQ_O, // level interrupt
    des_link_if.user lnk // engine link
);
    des_pkg::uc_state_t state_r;
    logic [3:0] cnt_r;
    des_pkg::block_t key_r;
    des_pkg::block_t din_r;
    des_pkg::block_t cap_r;
    logic way_r;
    logic pwatch_r;
    logic stream_r;
    logic gate_r;
    logic abort_r;
    logic rstn_r;
    logic [1:0] sticky_r;
    logic [1:0] mask_r;
    logic [31:0] rdata_r;
    logic irq_r;

    logic wr_ctrl_w;
    logic wr_stat_w;
    logic start_w;
    logic abort_req_w;
    logic [1:0] set_w;
    logic [1:0] clr_w;
    logic [1:0] sticky_nxt;
    logic [31:0] stat_w;
    logic [31:0] rd_mux_w;

    assign wr_ctrl_w = WR_I && (ADDR_I == `UC_CTRL_OFS);
    assign wr_stat_w = WR_I && (ADDR_I == `UC_STAT_OFS);
    assign start_w = wr_ctrl_w && WDATA_I[`CTRL_START_BIT];
    assign abort_req_w = wr_ctrl_w && WDATA_I[`CTRL_ABORT_BIT];
    assign set_w = {lnk.parity_fault, lnk.result_strobe};
    assign clr_w = wr_stat_w ? WDATA_I[1:0] : 2'h0;
    // a new event in the clearing cycle survives the write-one-to-clear
    assign sticky_nxt = (sticky_r & ~clr_w) | set_w;
    assign stat_w = {28'h0000000, (state_r == des_pkg::UC_RUN), lnk.parity_fault, sticky_r};
    assign rd_mux_w = (ADDR_I == `UC_CTRL_OFS) ? {27'h0000000, stream_r, 1'h0, pwatch_r, way_r, 1'h0} :
                      (ADDR_I == `UC_STAT_OFS) ? stat_w :
                      (ADDR_I == `UC_MASK_OFS) ? {30'h00000000, mask_r} :
                      (ADDR_I == `UC_KEYH_OFS) ? key_r[1:32] :
                      (ADDR_I == `UC_KEYL_OFS) ? key_r[33:64] :
                      (ADDR_I == `UC_DINH_OFS) ? din_r[1:32] :
                      (ADDR_I == `UC_DINL_OFS) ? din_r[33:64] :
                      (ADDR_I == `UC_DOUTH_OFS) ? cap_r[1:32] :
                      (ADDR_I == `UC_DOUTL_OFS) ? cap_r[33:64] : 32'h00000000;

    // register file and capture of finished blocks
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            key_r <= '0;
            din_r <= '0;
            cap_r <= '0;
            way_r <= `UC_WAY_RST;
            pwatch_r <= `UC_PWATCH_RST;
            stream_r <= `UC_STREAM_RST;
            sticky_r <= 2'h0;
            mask_r <= `UC_MASK_RST;
            rdata_r <= 32'h00000000;
            irq_r <= 1'b0;
            rstn_r <= 1'b0;
        end else if (CE_I) begin
            rstn_r <= 1'b1;
            rdata_r <= RD_I ? rd_mux_w : 32'h00000000;
            sticky_r <= sticky_nxt;
            irq_r <= |(sticky_nxt & mask_r);
            if (lnk.result_strobe) begin
                cap_r <= lnk.dout;
            end
            if (wr_ctrl_w) begin
                pwatch_r <= WDATA_I[`CTRL_PWATCH_BIT];
                stream_r <= WDATA_I[`CTRL_STREAM_BIT];
                // direction only moves between blocks so a block never sees it change
                if (state_r != des_pkg::UC_RUN) begin
                    way_r <= WDATA_I[`CTRL_WAY_BIT];
                end
            end
            if (WR_I && ADDR_I == `UC_MASK_OFS) begin
                mask_r <= WDATA_I[1:0];
            end
            if (WR_I && ADDR_I == `UC_KEYH_OFS) begin
                key_r[1:32] <= WDATA_I;
            end
            if (WR_I && ADDR_I == `UC_KEYL_OFS) begin
                key_r[33:64] <= WDATA_I;
            end
            if (WR_I && ADDR_I == `UC_DINH_OFS) begin
                din_r[1:32] <= WDATA_I;
            end
            if (WR_I && ADDR_I == `UC_DINL_OFS) begin
                din_r[33:64] <= WDATA_I;
            end
        end
    end

    // sequencer for the run gate and the abort pulse
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_r <= des_pkg::UC_IDLE;
            cnt_r <= `DES_CNT_ZERO;
            gate_r <= 1'b0;
            abort_r <= 1'b0;
        end else if (CE_I) begin
            case (state_r)
                des_pkg::UC_IDLE: begin
                    if (abort_req_w) begin
                        abort_r <= 1'b1;
                        state_r <= des_pkg::UC_CLEAR;
                    end else if (start_w) begin
                        gate_r <= 1'b1;
                        cnt_r <= `DES_CNT_ZERO;
                        state_r <= des_pkg::UC_RUN;
                    end
                end
                des_pkg::UC_RUN: begin
                    if (abort_req_w) begin
                        abort_r <= 1'b1;
                        gate_r <= 1'b0;
                        state_r <= des_pkg::UC_CLEAR;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `DES_CNT_LAST && !stream_r) begin
                            gate_r <= 1'b0;
                            state_r <= des_pkg::UC_IDLE;
                        end
                    end
                end
                des_pkg::UC_CLEAR: begin
                    abort_r <= 1'b0;
                    state_r <= des_pkg::UC_IDLE;
                end
                default: begin
                    gate_r <= 1'b0;
                    abort_r <= 1'b0;
                    state_r <= des_pkg::UC_IDLE;
                end
            endcase
        end
    end

    assign lnk.async_low_rst_n = rstn_r;
    assign lnk.abort_pulse = abort_r;
    assign lnk.run_gate = gate_r;
    assign lnk.cipher_way = way_r;
    assign lnk.parity_watch = pwatch_r;
    assign lnk.key = key_r;
    assign lnk.din = din_r;
    assign RDATA_O = rdata_r;
    assign IRQ_O = irq_r;
endmodule

/* des_link_chk.sv */
// checker: timing relations on the link between user controller and cipher engine
`timescale 1ns/100ps
module des_link_chk (
    input wire logic SYS_CLK_I, // system clock
    input wire logic RST_I, // synchronous reset, active high
    input wire logic CE_I, // engine clock enable
    input wire logic async_low_rst_n, // engine asynchronous reset, active low
    input wire logic abort_pulse, // engine clear
    input wire logic run_gate, // round advance gate
    input wire logic cipher_way, // 1 encrypt, 0 decrypt
    input wire logic parity_watch, // key parity check on
    input wire des_pkg::block_t key, // cipher key
    input wire des_pkg::block_t din, // input block
    input wire des_pkg::block_t dout, // result block
    input wire logic result_strobe, // result valid pulse
    input wire logic parity_fault // key parity fault
);
    logic [3:0] cnt_r;
    logic strb_exp_r;
    logic [7:0] even_w;
    wire rst_w = RST_I || !async_low_rst_n;
    wire gated_w = CE_I && run_gate && !abort_pulse;
    wire fault_w = parity_watch && (|even_w);
    for (genvar b = 0; b < 8; b++) begin : g_byte
        assign even_w[b] = ~^key[8*b+1 +: 8];
    end
    // reference round count; abort wins over the gate, a frozen enable holds everything
    always_ff @(posedge SYS_CLK_I) begin
        if (rst_w || (CE_I && abort_pulse)) begin
            cnt_r <= 4'h0;
            strb_exp_r <= 1'b0;
        end else if (CE_I) begin
            cnt_r <= cnt_r + (gated_w ? 4'h1 : 4'h0);
            strb_exp_r <= gated_w && (cnt_r == 4'hF);
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (rst_w);
    a_strobe_after_sixteen: assert property (result_strobe == strb_exp_r)
        else $error("result strobe not one cycle after the sixteenth gated round");
    a_strobe_one_cycle: assert property (result_strobe && CE_I |=> !result_strobe)
        else $error("result strobe longer than one cycle");
    a_fault_lag: assert property (CE_I |=> parity_fault == $past(fault_w))
        else $error("parity fault does not follow key parity and check enable");
    a_dout_only_strobe: assert property (!$stable(dout) |-> result_strobe)
        else $error("result block changed without a result strobe");
    a_abort_quiet: assert property (abort_pulse && CE_I |=> !result_strobe [*8])
        else $error("result strobe soon after an abort");
    a_abort_one_pulse: assert property (abort_pulse |=> !abort_pulse)
        else $error("abort held longer than one cycle");
    a_way_steady: assert property (cnt_r != 4'h0 |-> $stable(cipher_way))
        else $error("direction changed inside a block");
    a_reset_idle: assert property ($rose(async_low_rst_n) |-> !result_strobe && !parity_fault)
        else $error("engine outputs not idle after reset");
endmodule

/* tb.sv */
// testbench: cipher runs driven through the controller registers into the engine
`timescale 1ns/100ps
`include "des_regs.svh"
module tb;
    typedef struct {des_pkg::block_t key; des_pkg::block_t din; des_pkg::block_t exp;
        logic way; logic watch; logic fault; int hold;} row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce_eng = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] rv;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    // last two keys have every parity bit flipped: same cipher result, bad parity
    row_t rows [6] = '{
        '{64'h133457799BBCDFF1, 64'h0123456789ABCDEF, 64'h85E813540F0AB405, 1'b1, 1'b1, 1'b0, 0},
        '{64'h133457799BBCDFF1, 64'h85E813540F0AB405, 64'h0123456789ABCDEF, 1'b0, 1'b0, 1'b0, 3},
        '{64'h0E329232EA6D0D73, 64'h8787878787878787, 64'h0000000000000000, 1'b1, 1'b1, 1'b0, 0},
        '{64'h0E329232EA6D0D73, 64'h0000000000000000, 64'h8787878787878787, 1'b0, 1'b1, 1'b0, 0},
        '{64'h123556789ABDDEF0, 64'h0123456789ABCDEF, 64'h85E813540F0AB405, 1'b1, 1'b1, 1'b1, 0},
        '{64'h123556789ABDDEF0, 64'h0123456789ABCDEF, 64'h85E813540F0AB405, 1'b1, 1'b0, 1'b0, 0}};
    des_link_if link ();
    des_engine des_engine_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .CE_I(ce_eng), .lnk(link));
    des_user_ctrl des_user_ctrl_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .CE_I(ce_eng), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq), .lnk(link));
    des_link_chk des_link_chk_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .CE_I(ce_eng),
        .async_low_rst_n(link.async_low_rst_n), .abort_pulse(link.abort_pulse), .run_gate(link.run_gate),
        .cipher_way(link.cipher_way), .parity_watch(link.parity_watch), .key(link.key), .din(link.din),
        .dout(link.dout), .result_strobe(link.result_strobe), .parity_fault(link.parity_fault));
    always #50 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        @(posedge sys_clk);
        d = rdata;
    endtask
    task automatic load_go(input row_t r, input logic strm = 1'b0);
        wr(`UC_KEYH_OFS, r.key[1:32]);
        wr(`UC_KEYL_OFS, r.key[33:64]);
        wr(`UC_DINH_OFS, r.din[1:32]);
        wr(`UC_DINL_OFS, r.din[33:64]);
        wr(`UC_CTRL_OFS, {27'h0, strm, 1'b0, r.watch, r.way, 1'b1});
    endtask
    // counts edges after the last write; optionally freezes both ends mid-block, as a full sink would
    // the controller shares the enable, otherwise its gate count would run ahead of a frozen engine
    task automatic wait_strb(input int hold);
        n = 0;
        while (link.result_strobe !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            ce_eng <= !(n >= 5 && n < 5 + hold);
            if (n > 60) begin
                bad_count++;
                give_verdict();
            end
        end
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        chk("idle outputs", {link.result_strobe, link.parity_fault}, 2'h0);
        rd(`UC_CTRL_OFS, rv);
        chk("ctrl reset", rv, 32'h2);
        rd(`UC_STAT_OFS, rv);
        chk("status reset", rv, 32'h0);
        rd(`UC_MASK_OFS, rv);
        chk("mask reset", rv, 32'h0);
        wr(8'h30, 32'hFFFFFFFF);
        rd(8'h30, rv);
        chk("unmapped", rv, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(`UC_MASK_OFS, {31'h0, i[0]});
            load_go(rows[i]);
            wait_strb(rows[i].hold);
            chk("cycles", n, 17 + rows[i].hold);
            chk("engine out", link.dout, rows[i].exp);
            rd(`UC_DOUTH_OFS, rv);
            chk("out hi", rv, rows[i].exp[1:32]);
            rd(`UC_DOUTL_OFS, rv);
            chk("out lo", rv, rows[i].exp[33:64]);
            rd(`UC_STAT_OFS, rv);
            chk("status", rv, {29'h0, rows[i].fault, rows[i].fault, 1'b1});
            chk("irq on", irq, i[0]);
            wr(`UC_CTRL_OFS, {30'h0, rows[i].way, 1'b0});
            rd(`UC_CTRL_OFS, rv);
            chk("ctrl readback", rv, {30'h0, rows[i].way, 1'b0});
            wr(`UC_STAT_OFS, 32'h3);
            rd(`UC_STAT_OFS, rv);
            chk("status clear", rv, 32'h0);
            chk("irq off", irq, 1'b0);
        end
        load_go(rows[0]);
        repeat (5) @(posedge sys_clk);
        wr(`UC_CTRL_OFS, 32'hA);
        n = 0;
        repeat (30) begin
            @(posedge sys_clk);
            n += (link.result_strobe === 1'b1) ? 1 : 0;
        end
        chk("strobes after abort", n, 0);
        load_go(rows[2]);
        wait_strb(0);
        chk("cycles after abort", n, 17);
        chk("out after abort", link.dout, rows[2].exp);
        // stream mode: the next key and block are loaded mid-block, taken at round zero
        load_go(rows[0], 1'b1);
        load_go(rows[2], 1'b1);
        wait_strb(0);
        chk("stream first", link.dout, rows[0].exp);
        wr(`UC_CTRL_OFS, 32'h6);
        wait_strb(0);
        // the stop write uses two of the sixteen edges between strobes
        chk("stream period", n, 16 - 2);
        chk("stream second", link.dout, rows[2].exp);
        rd(`UC_STAT_OFS, rv);
        chk("stream stopped", rv[`STAT_BUSY_BIT], 1'b0);
        give_verdict();
    end
endmodule
